// >>> logic/saif_pkg.sv
// Contract
// - Subsystem runs only while enable bit set
// - Twenty-three selections; positive pin, temperature, supply
// - Negative side: pin, reference input, ground
// - Ground negative gives single-ended, else differential
// - Separate positive and negative channel-select registers
// - Each conversion loads high and low result bytes
// - Control bit 0 picks right or left justify
// - Single-ended unsigned; full scale 0x03FF or 0xFFC0
// - Single-ended unused result bits read zero
// - Differential two's complement, limits 0x01FF, 0xFE00, 0x8000
// - Right-justified differential sign-extends high byte
// - Left-justified differential zero low bits, 0x7FC0
// - Busy during conversion; its fall at completion sets done flag, an abort clears it without the flag
// - Conversion clock is system clock over divide+1
package saif_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CODE_W = 10;
  localparam int RESULT_W = 16;
  localparam int DIV_W = 5;
  localparam int SEL_W = 5;
  localparam int REG_W = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_W = 4;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_POS_SEL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_NEG_SEL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_RESULT_HIGH = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_RESULT_LOW = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_LJST_BIT = 0;
  localparam int CTL_BUSY_BIT = 4;
  localparam int CTL_ENABLE_BIT = 7;
  localparam int IRQ_DONE_BIT = 0;

  // ----------------------------------------------------------------
  // Channel codes
  // ----------------------------------------------------------------
  localparam logic [SEL_W-1:0] SEL_PIN_LAST = 5'h14;
  localparam logic [SEL_W-1:0] POS_TEMP = 5'h1E;
  localparam logic [SEL_W-1:0] POS_SUPPLY = 5'h1F;
  localparam logic [SEL_W-1:0] NEG_VREF = 5'h1E;
  localparam logic [SEL_W-1:0] NEG_GND = 5'h1F;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [SEL_W-1:0] POS_RESET = 5'h00;
  localparam logic [SEL_W-1:0] NEG_RESET = 5'h1F;
  localparam logic [DIV_W-1:0] DIV_RESET = 5'h1F;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_TRACK = 3'b010,
    ST_CONV = 3'b100
  } saif_state_e;

endpackage

// >>> logic/saif_result_format.sv
`timescale 1ns/1ns
module saif_result_format #(
  parameter int CODE_W = saif_pkg::CODE_W,
  parameter int RESULT_W = saif_pkg::RESULT_W
) (
  // Raw converter code, offset binary
  input wire logic [CODE_W-1:0] raw_code,
  // Format controls
  input wire logic single_ended,
  input wire logic left_justify,
  // Packed result pair
  output logic [RESULT_W-1:0] result_word
);
  import saif_pkg::*;

  localparam int PAD_W = RESULT_W - CODE_W;

  initial begin
    if (PAD_W < 1) begin
      $error("result pair must be wider than the code");
    end
  end

  logic [CODE_W-1:0] value;

  always_comb begin
    // Differential codes are offset binary from the SAR; flipping the top bit gives two's complement
    value = single_ended ? raw_code : {~raw_code[CODE_W-1], raw_code[CODE_W-2:0]};
    if (left_justify) begin
      result_word = {value, {PAD_W{1'b0}}};
    end else if (single_ended) begin
      result_word = {{PAD_W{1'b0}}, value};
    end else begin
      result_word = {{PAD_W{value[CODE_W-1]}}, value};
    end
  end

endmodule

// >>> logic/saif_converter.sv
`timescale 1ns/1ns
module saif_converter #(
  parameter int DIV_W = saif_pkg::DIV_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [saif_pkg::ADDR_W-1:0] paddr,
  input wire logic [saif_pkg::DATA_W-1:0] pwdata,
  output logic [saif_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog front end
  input wire logic comparator_high,
  output logic converter_power_on,
  output logic [saif_pkg::SEL_W-1:0] positive_select,
  output logic [saif_pkg::SEL_W-1:0] negative_select,
  output logic single_ended_mode,
  output logic sample_hold,
  output logic [saif_pkg::CODE_W-1:0] dac_trial_code,
  // Status
  output logic conversion_busy,
  output logic irq
);
  import saif_pkg::*;

  initial begin
    if (DIV_W < 1 || DIV_W > REG_W) begin
      $error("divide field width out of range");
    end
  end

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic enable_reg;
  logic ljst_reg;
  logic [SEL_W-1:0] pos_sel_reg;
  logic [SEL_W-1:0] neg_sel_reg;
  logic [DIV_W-1:0] div_reg;
  logic [RESULT_W-1:0] result_reg;
  logic irq_status_reg;
  logic irq_enable_reg;
  saif_state_e state_reg;
  logic [DIV_W-1:0] div_cnt_reg;
  logic [DIV_W-1:0] div_latched_reg;
  logic [IDX_W-1:0] bit_idx_reg;
  logic [CODE_W-1:0] code_reg;
  logic conv_single_reg;
  logic [DATA_W-1:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic power_reg;
  logic se_mode_reg;
  logic busy_reg;
  logic irq_reg;

  logic [CODE_W-1:0] code_next;
  logic [RESULT_W-1:0] format_word;
  logic wr_en;
  logic rd_en;
  logic conv_tick;
  logic start_req;
  logic done_pulse;
  logic [REG_W-1:0] read_value;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    case (addr)
      OFS_CONTROL, OFS_POS_SEL, OFS_NEG_SEL, OFS_CONFIG, OFS_RESULT_HIGH,
      OFS_RESULT_LOW, OFS_IRQ_STATUS, OFS_IRQ_ENABLE, OFS_IRQ_CLEAR: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic write_hit(input logic [ADDR_W-1:0] ofs);
    write_hit = wr_en && (paddr == ofs);
  endfunction

  // ----------------------------------------------------------------
  // APB access
  // ----------------------------------------------------------------
  // One wait state: answer is built in the first access cycle, so decode never sits in the output path
  assign rd_en = psel && penable && !pready_reg;
  assign wr_en = psel && penable && pwrite && pready_reg && is_mapped(paddr);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else if (clk_en) begin
      pready_reg <= rd_en;
      pslverr_reg <= rd_en && !is_mapped(paddr);
      if (rd_en) begin
        prdata_reg <= {{(DATA_W-REG_W){1'b0}}, read_value};
      end
    end
  end

  always_comb begin
    read_value = '0;
    case (paddr)
      OFS_CONTROL: begin
        read_value[CTL_LJST_BIT] = ljst_reg;
        read_value[CTL_BUSY_BIT] = busy_reg;
        read_value[CTL_ENABLE_BIT] = enable_reg;
      end
      OFS_POS_SEL: read_value[SEL_W-1:0] = pos_sel_reg;
      OFS_NEG_SEL: read_value[SEL_W-1:0] = neg_sel_reg;
      OFS_CONFIG: read_value[DIV_W-1:0] = div_reg;
      OFS_RESULT_HIGH: read_value = result_reg[RESULT_W-1:REG_W];
      OFS_RESULT_LOW: read_value = result_reg[REG_W-1:0];
      OFS_IRQ_STATUS: read_value[IRQ_DONE_BIT] = irq_status_reg;
      OFS_IRQ_ENABLE: read_value[IRQ_DONE_BIT] = irq_enable_reg;
      default: read_value = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      enable_reg <= 1'b0;
      ljst_reg <= 1'b0;
    end else if (clk_en && write_hit(OFS_CONTROL)) begin
      enable_reg <= pwdata[CTL_ENABLE_BIT];
      ljst_reg <= pwdata[CTL_LJST_BIT];
    end
  end

  // Reserved codes are stored as written; the mux treats them as no connection
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pos_sel_reg <= POS_RESET;
      neg_sel_reg <= NEG_RESET;
    end else if (clk_en) begin
      if (write_hit(OFS_POS_SEL)) begin
        pos_sel_reg <= pwdata[SEL_W-1:0];
      end
      if (write_hit(OFS_NEG_SEL)) begin
        neg_sel_reg <= pwdata[SEL_W-1:0];
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      div_reg <= DIV_W'(DIV_RESET);
    end else if (clk_en && write_hit(OFS_CONFIG)) begin
      div_reg <= pwdata[DIV_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Analog front-end drive
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      power_reg <= 1'b0;
      se_mode_reg <= 1'b0;
    end else if (clk_en) begin
      power_reg <= enable_reg;
      se_mode_reg <= (neg_sel_reg == NEG_GND);
    end
  end

  // ----------------------------------------------------------------
  // Conversion clock divider
  // ----------------------------------------------------------------
  // Divide value is latched at start so a mid-conversion write cannot stretch the current one
  assign conv_tick = (state_reg != ST_IDLE) && (div_cnt_reg == div_latched_reg);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt_reg <= '0;
      div_latched_reg <= DIV_W'(DIV_RESET);
    end else if (clk_en) begin
      if (start_req) begin
        div_cnt_reg <= '0;
        div_latched_reg <= div_reg;
      end else if (conv_tick) begin
        div_cnt_reg <= '0;
      end else if (state_reg != ST_IDLE) begin
        div_cnt_reg <= div_cnt_reg + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Successive approximation sequencer
  // ----------------------------------------------------------------
  assign start_req = write_hit(OFS_CONTROL) && pwdata[CTL_ENABLE_BIT] && pwdata[CTL_BUSY_BIT]
                     && (state_reg == ST_IDLE);
  assign done_pulse = enable_reg && (state_reg == ST_CONV) && conv_tick && (bit_idx_reg == '0);

  always_comb begin
    code_next = code_reg;
    if (!comparator_high) begin
      code_next[bit_idx_reg] = 1'b0;
    end
    if (bit_idx_reg != '0) begin
      code_next[bit_idx_reg - 1'b1] = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      bit_idx_reg <= '0;
      code_reg <= '0;
      conv_single_reg <= 1'b0;
    end else if (clk_en) begin
      if (!enable_reg) begin
        state_reg <= ST_IDLE;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            if (start_req) begin
              state_reg <= ST_TRACK;
              conv_single_reg <= (neg_sel_reg == NEG_GND);
            end
          end
          ST_TRACK: begin
            if (conv_tick) begin
              state_reg <= ST_CONV;
              bit_idx_reg <= IDX_W'(CODE_W - 1);
              code_reg <= CODE_W'(1) << (CODE_W - 1);
            end
          end
          ST_CONV: begin
            if (conv_tick) begin
              code_reg <= code_next;
              if (bit_idx_reg == '0) begin
                state_reg <= ST_IDLE;
              end else begin
                bit_idx_reg <= bit_idx_reg - 1'b1;
              end
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      busy_reg <= 1'b0;
    end else if (clk_en) begin
      busy_reg <= enable_reg && (start_req || ((state_reg != ST_IDLE) && !done_pulse));
    end
  end

  // ----------------------------------------------------------------
  // Result formatting
  // ----------------------------------------------------------------
  saif_result_format #(
    .CODE_W(CODE_W),
    .RESULT_W(RESULT_W)
  ) u_format (
    .raw_code(code_next),
    .single_ended(conv_single_reg),
    .left_justify(ljst_reg),
    .result_word(format_word)
  );

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      result_reg <= RESULT_RESET;
    end else if (clk_en && done_pulse) begin
      result_reg <= format_word;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_status_reg <= 1'b0;
      irq_enable_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else if (clk_en) begin
      if (done_pulse) begin
        irq_status_reg <= 1'b1;
      end else if (write_hit(OFS_IRQ_CLEAR) && pwdata[IRQ_DONE_BIT]) begin
        irq_status_reg <= 1'b0;
      end
      if (write_hit(OFS_IRQ_ENABLE)) begin
        irq_enable_reg <= pwdata[IRQ_DONE_BIT];
      end
      irq_reg <= irq_status_reg && irq_enable_reg;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign converter_power_on = power_reg;
  assign positive_select = pos_sel_reg;
  assign negative_select = neg_sel_reg;
  assign single_ended_mode = se_mode_reg;
  assign sample_hold = busy_reg;
  assign dac_trial_code = code_reg;
  assign conversion_busy = busy_reg;
  assign irq = irq_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock iff clk_en); endclocking
  default disable iff (!reset_n);

  sequence s_done_se_right;
    done_pulse && conv_single_reg && !ljst_reg;
  endsequence

  sequence s_tick_gap4;
    !conv_tick [*3] ##1 conv_tick;
  endsequence

  a_shutdown_idle: assert property (!enable_reg |=> !converter_power_on && state_reg == ST_IDLE)
    else $error("converter active while disabled");
  a_mode_from_ground: assert property (1'b1 |=> single_ended_mode == ($past(neg_sel_reg) == NEG_GND))
    else $error("single-ended mode does not follow ground selection");
  a_done_sets_flag: assert property (done_pulse |=> irq_status_reg && !conversion_busy)
    else $error("completion did not clear busy and set done flag");
  a_irq_follows: assert property (irq_status_reg && irq_enable_reg |=> irq)
    else $error("enabled done flag did not raise interrupt");
  a_result_hold: assert property (!done_pulse |=> $stable(result_reg))
    else $error("result changed without completion");
  a_se_full_scale: assert property (s_done_se_right and (code_next == '1) |=> result_reg == 16'h03FF)
    else $error("single-ended full scale wrong");
  a_se_pad_zero: assert property (done_pulse && conv_single_reg |=> (ljst_reg ? result_reg[5:0] == '0
      : result_reg[15:10] == '0))
    else $error("single-ended unused bits not zero");
  a_diff_sign_ext: assert property (done_pulse && !conv_single_reg && !ljst_reg
      |=> result_reg[15:10] == {6{result_reg[9]}})
    else $error("differential sign extension wrong");
  a_diff_left_low: assert property (done_pulse && !conv_single_reg && ljst_reg && code_next == '1
      |=> result_reg == 16'h7FC0)
    else $error("differential left positive full scale wrong");
  a_diff_neg_limit: assert property (done_pulse && !conv_single_reg && !ljst_reg && code_next == '0
      |=> result_reg == 16'hFE00)
    else $error("differential negative limit wrong");
  // A software abort legally cuts the tick train, so the check stands down with the enable
  a_tick_spacing: assert property (disable iff (!reset_n || !enable_reg) conv_tick && div_latched_reg == 5'd3
      && bit_idx_reg > 4'd1
      |=> s_tick_gap4)
    else $error("conversion clock spacing wrong");

endmodule

// >>> bench/saif_analog_model.sv
`timescale 1ns/1ns
module saif_analog_model (
  // Clock
  input wire logic clock,
  // From converter
  input wire logic power_on,
  input wire logic [9:0] trial_code,
  // Level set by bench, as raw offset-binary code
  input wire logic [9:0] level,
  // To converter
  output logic comparator_high
);
  logic toggle_reg = 1'b0;

  // ----------------------------------------------------------------
  // Comparator
  // ----------------------------------------------------------------
  // Powered down the comparator output is junk, so it keeps changing
  always_ff @(posedge clock) begin
    toggle_reg <= ~toggle_reg;
  end

  always_comb begin
    if (power_on) begin
      // Selected pins are taken as analog inputs skipped by the crossbar
      comparator_high = (level >= trial_code);
    end else begin
      comparator_high = toggle_reg;
    end
  end
endmodule

// >>> bench/sar_adc_input_and_result_format_bench.sv
`timescale 1ns/1ns
module sar_adc_input_and_result_format_bench;
  import saif_pkg::*;
  logic clock = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic pready, pslverr, comparator_high, power_on, se_mode, sample_hold, busy, irq, err;
  logic [4:0] pos_sel, neg_sel;
  logic [9:0] trial, level = '0, rv;
  int bad_count = 0, n_tests = 0, cycles = 0, seed = 32'h57a8, ie = 0, m_res = 0, dv;

  always #50 clock = ~clock;

  saif_converter saif_converter_inst (.clock(clock), .reset_n(reset_n), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .comparator_high(comparator_high), .converter_power_on(power_on),
    .positive_select(pos_sel), .negative_select(neg_sel), .single_ended_mode(se_mode),
    .sample_hold(sample_hold), .dac_trial_code(trial), .conversion_busy(busy), .irq(irq));

  saif_analog_model saif_analog_model_inst (.clock(clock), .power_on(power_on), .trial_code(trial),
    .level(level), .comparator_high(comparator_high));

  task close_out;
    $display("tests %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Hang guard, generous for seventeen conversions of 11 ticks at most 32 cycles apart
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count = bad_count + 1;
      close_out();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // APB master
  // ----------------------------------------------------------------
  // Ready is read at the rising edge, before the design's updates of that edge land
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task read_result;
    apb(0, OFS_RESULT_HIGH, 0);
    check(q, 32'(m_res[15:8]));
    apb(0, OFS_RESULT_LOW, 0);
    check(q, 32'(m_res[7:0]));
  endtask

  task convert(input logic [4:0] neg, input logic lj, input logic [9:0] raw);
    int cnt;
    logic se;
    logic [9:0] v;
    level <= raw;
    apb(1, OFS_CONFIG, dv);
    apb(1, OFS_NEG_SEL, 32'(neg));
    apb(1, OFS_CONTROL, 32'h0000_0090 | 32'(lj));
    cnt = 0;
    do begin
      @(posedge clock);
      if (busy === 1'b1) cnt = cnt + 1;
    end while ((busy === 1'b1 || cnt == 0) && cnt < 2000);
    check(cnt, 11 * (dv + 1));
    se = (neg == NEG_GND);
    v = se ? raw : raw ^ 10'h200;
    m_res = lj ? {v, 6'h0} : (se ? {6'h0, v} : {{6{v[9]}}, v});
    check(32'(se_mode), 32'(se));
    check(32'(power_on), 1);
    check(32'(neg_sel), 32'(neg));
    check(32'(sample_hold), 0);
    check(32'(trial), 32'(raw));
    read_result();
    apb(0, OFS_IRQ_STATUS, 0);
    check(q, 1);
    check(32'(irq), ie);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  logic [7:0] ra[8] = '{OFS_CONTROL, OFS_POS_SEL, OFS_NEG_SEL, OFS_CONFIG, OFS_RESULT_HIGH, OFS_RESULT_LOW,
    OFS_IRQ_STATUS, OFS_IRQ_ENABLE};
  logic [7:0] rx[8] = '{8'h00, 8'h00, 8'h1F, 8'h1F, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [9:0] edge_codes[3] = '{10'h3FF, 10'h000, 10'h200};
  logic [4:0] pos_codes[4] = '{5'h00, SEL_PIN_LAST, POS_TEMP, POS_SUPPLY};

  initial begin
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    foreach (ra[i]) begin
      apb(0, ra[i], 0);
      check(q, 32'(rx[i]));
    end
    apb(0, 8'h24, 0);
    check(32'(err), 1);
    check(q, 0);
    $display("reset values done");
    foreach (pos_codes[i]) begin
      apb(1, OFS_POS_SEL, 32'(pos_codes[i]));
      repeat (2) @(posedge clock);
      check(32'(pos_sel), 32'(pos_codes[i]));
    end
    apb(1, OFS_CONTROL, 32'h0000_0080);
    apb(1, OFS_IRQ_ENABLE, 1);
    check(32'(power_on), 1);
    ie = 1;
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 4; j++) begin
        dv = (k == 0 && j == 0) ? 31 : ($random(seed) & 3);
        rv = (j < 3) ? edge_codes[j] : 10'($random(seed));
        convert(k[1] ? NEG_GND : ((j == 3) ? 5'(j) : NEG_VREF), k[0], rv);
        apb(1, OFS_IRQ_CLEAR, 1);
        apb(0, OFS_IRQ_STATUS, 0);
        check(q, 0);
        check(32'(irq), 0);
      end
    end
    $display("conversions done");
    apb(1, OFS_IRQ_ENABLE, 0);
    ie = 0;
    convert(NEG_GND, 1'b0, 10'h155);
    apb(1, OFS_CONTROL, 32'h0000_0081);
    read_result();
    $display("hold and mask done");
    apb(1, OFS_IRQ_CLEAR, 1);
    level <= 10'h2AA;
    apb(1, OFS_CONTROL, 32'h0000_0090);
    repeat (5) @(posedge clock);
    apb(1, OFS_CONTROL, 0);
    repeat (40) @(posedge clock);
    check(32'(busy), 0);
    check(32'(power_on), 0);
    apb(0, OFS_IRQ_STATUS, 0);
    check(q, 0);
    read_result();
    $display("abort done");
    close_out();
  end
endmodule
